//--- contact_panel.sv
// Contact switch panel on the far side of the limit and mode switch inputs.
// Assumes close requests change right after a rising clock edge.
`timescale 1ns/100ps
module contact_panel (
  input wire logic sys_clk_i, // Control clock
  input wire logic [2:0] close_i, // Close request: mode switch, rev, fwd
  output logic fwd_n_o, // Forward contact line
  output logic rev_n_o, // Reverse contact line
  output logic msw_n_o // Mode switch contact line
);
  logic [2:0] closed_reg = 3'h0;
  // Contacts settle one clock after the request, like a relay
  always_ff @(posedge sys_clk_i) begin
    closed_reg <= close_i;
  end
  assign {msw_n_o, rev_n_o, fwd_n_o} = ~closed_reg;
endmodule : contact_panel

//--- out_pair_route.sv
// Routes one of five active-low indications onto an output pin pair.
// Assumes all indications are active-low levels synchronous to sys_clk_i.
`timescale 1ns/100ps
module out_pair_route
  import servo_torque_limit_pkg::*;
(
  input wire logic sys_clk_i, // Drive control clock
  input wire logic arst_n_i, // Async reset, low
  input wire logic [`FUNC_W-1:0] func_i, // Selector code
  input wire logic position_mode_i, // High in position control
  input wire logic position_done_out_n_i, // Positioning complete, low
  input wire logic velocity_match_out_n_i, // Speed coincidence, low
  input wire logic rotating_out_n_i, // Rotation detected, low
  input wire logic servo_ready_n_i, // Servo ready, low
  input wire logic clamped_n_i, // Torque clamped, low
  input wire logic brake_interlock_out_n_i, // Brake interlock, low
  output logic pair_n_o // Pin pair level, low is on
);
  route_s st_reg;
  route_s st_next;

  // Selector decode; unknown codes leave the pair off
  always_comb begin
    st_next = st_reg;
    case (out_func_e'(func_i))
      // R9 code routing
      FUNC_DONE: st_next.pin_n = position_mode_i ? position_done_out_n_i : velocity_match_out_n_i;
      FUNC_ROTATING: st_next.pin_n = rotating_out_n_i;
      FUNC_READY: st_next.pin_n = servo_ready_n_i;
      // R8 clamp indication
      FUNC_CLAMPED: st_next.pin_n = clamped_n_i;
      FUNC_BRAKE: st_next.pin_n = brake_interlock_out_n_i;
      default: st_next.pin_n = 1'b1;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= '{pin_n: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pair_n_o = st_reg.pin_n;

  a_clamp_route: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R8
    func_i == FUNC_CLAMPED |=> pair_n_o == $past(clamped_n_i))
    else $error("clamp code not routed");
  a_ready_route: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R9
    func_i == FUNC_READY |=> pair_n_o == $past(servo_ready_n_i))
    else $error("ready code not routed");
endmodule : out_pair_route

//--- servo_torque_limit_params.svh
// Constants of the torque-limit selection block: offsets, reset values, field positions.
// Assumes byte addresses on an 8-bit register address, one 32-bit word per register.
`ifndef SERVO_TORQUE_LIMIT_PARAMS_SVH
`define SERVO_TORQUE_LIMIT_PARAMS_SVH

// Register byte offsets
`define OFS_FWD_INT_LIMIT 8'h00
`define OFS_REV_INT_LIMIT 8'h04
`define OFS_FWD_EXT_LIMIT 8'h08
`define OFS_REV_EXT_LIMIT 8'h0c
`define OFS_MOTOR_MAX 8'h10
`define OFS_CONTROL_MODE 8'h14
`define OFS_PAIR_A_FUNC 8'h18
`define OFS_PAIR_B_FUNC 8'h1c
`define OFS_PAIR_C_FUNC 8'h20
`define OFS_PRESET_ONE 8'h24
`define OFS_PRESET_TWO 8'h28
`define OFS_PRESET_THREE 8'h2c
`define OFS_STATUS 8'h30
`define OFS_IRQ_STATUS 8'h34
`define OFS_IRQ_CLEAR 8'h38
`define OFS_IRQ_ENABLE 8'h3c

// Widths
`define LIM_W 9
`define MODE_W 4
`define FUNC_W 3
`define SPD_W 16
`define TRQ_W 16
`define IRQ_W 3

// Ranges and reset values, limits in percent
`define LIM_PCT_MAX 9'h12c
`define INT_LIMIT_RST 9'h12c
`define EXT_LIMIT_RST 9'h064
`define MOTOR_MAX_RST 9'h12c
`define MODE_RST 4'h0
`define MODE_MAX 4'hd
`define SPEED_MODE_LO 4'h3
`define SPEED_MODE_HI 4'h6
`define FUNC_MAX 3'h4
`define PAIR_A_RST 3'h0
`define PAIR_B_RST 3'h1
`define PAIR_C_RST 3'h2
`define PRESET_RST 16'h0000

// Interrupt bit positions
`define IRQ_CLAMP_ON 0
`define IRQ_CLAMP_OFF 1
`define IRQ_SEL_CHG 2

`endif

//--- servo_torque_limit_pkg.sv
// Types of the torque-limit selection block.
// Assumes the constants header is on the include path.
package servo_torque_limit_pkg;
  `include "servo_torque_limit_params.svh"

  // Output pair functions, in selector code order
  typedef enum logic [`FUNC_W-1:0] {
    FUNC_DONE, FUNC_ROTATING, FUNC_READY, FUNC_CLAMPED, FUNC_BRAKE
  } out_func_e;

  // Preset speed selection
  typedef enum logic [1:0] {
    SEL_MODE_SWITCH, SEL_ONE, SEL_TWO, SEL_THREE
  } spd_sel_e;

  typedef struct packed {
    logic pin_n;
  } route_s;

  typedef struct packed {
    logic [`LIM_W-1:0] fwd_int;
    logic [`LIM_W-1:0] rev_int;
    logic [`LIM_W-1:0] fwd_ext;
    logic [`LIM_W-1:0] rev_ext;
    logic [`LIM_W-1:0] motor_max;
    logic [`MODE_W-1:0] mode;
    logic [`FUNC_W-1:0] func_a;
    logic [`FUNC_W-1:0] func_b;
    logic [`FUNC_W-1:0] func_c;
    logic [`SPD_W-1:0] spd1;
    logic [`SPD_W-1:0] spd2;
    logic [`SPD_W-1:0] spd3;
    logic fwd_on;
    logic rev_on;
    logic msw_on;
    logic [`TRQ_W-1:0] torque_out;
    logic clamped;
    spd_sel_e spd_sel;
    logic dir_rev;
    logic [`SPD_W-1:0] spd_out;
    logic [`IRQ_W-1:0] irq_stat;
    logic [`IRQ_W-1:0] irq_en;
    logic [31:0] rdata;
  } core_s;
endpackage : servo_torque_limit_pkg

//--- servo_torque_limit_select.sv
// Torque-limit selection, clamp indication, preset speed decode and output pair routing.
// Assumes contact inputs already synchronous to sys_clk_i, one clock per control cycle.
// Behaviour
// R1 - With the forward external input on, forward torque is clamped to the forward external limit.
// R2 - With the reverse external input on, reverse torque is clamped to the reverse external limit.
// R3 - With a direction's external input off, that direction uses its internal limit.
// R4 - The clamp output is low while the torque reference exceeds the active limit, else high.
// R5 - Software should keep limits at or below motor maximum and large enough to accelerate.
// R6 - Three output pair selectors each accept codes zero to four only.
// R7 - After reset the pair selectors hold codes 0, 1 and 2.
// R8 - A pair with selector code 3 carries the clamp indication.
// R9 - Codes 0, 1, 2 and 4 route done or speed match, rotating, ready and brake interlock.
// R10 - In modes 0 to 2 and 7 to 13 the two inputs are external limit enables.
// R11 - In modes 3 to 6 the two inputs select a preset speed and mode switch gives direction.
// R12 - A contact input at high level is off and at low level is on.
// R13 - External limits accept zero to three hundred percent and reset to one hundred.
// R14 - A limit above the motor maximum torque is replaced by the motor maximum.
// R15 - Inputs are sampled each cycle and the new limit is applied in the following cycle.
// R16 - Forward limit clamps positive values, reverse limit negative ones, keeping the sign.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps
module servo_torque_limit_select
  import servo_torque_limit_pkg::*;
(
  input wire logic sys_clk_i, // 40 MHz control clock
  input wire logic arst_n_i, // Async reset, low
  input wire logic [7:0] reg_addr_i, // Register byte address
  input wire logic [31:0] reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  output logic [31:0] reg_rdata_o, // Read data, cycle after strobe
  input wire logic fwd_ext_limit_in_n_i, // Forward limit contact, low on
  input wire logic rev_ext_limit_in_n_i, // Reverse limit contact, low on
  input wire logic mode_switch_in_n_i, // Mode switch contact, low on
  input wire logic [`TRQ_W-1:0] torque_ref_i, // Signed torque reference, percent
  output logic [`TRQ_W-1:0] torque_lim_o, // Signed limited torque
  output logic torque_clamped_out_n_o, // Low while clamping
  input wire logic position_mode_i, // High in position control
  input wire logic position_done_out_n_i, // Positioning complete, low
  input wire logic velocity_match_out_n_i, // Speed coincidence, low
  input wire logic rotating_out_n_i, // Rotation detected, low
  input wire logic servo_ready_n_i, // Servo ready, low
  input wire logic brake_interlock_out_n_i, // Brake interlock, low
  output logic pair_a_n_o, // Output pair A, low on
  output logic pair_b_n_o, // Output pair B, low on
  output logic pair_c_n_o, // Output pair C, low on
  output logic preset_one_sel_o, // Preset speed one chosen
  output logic preset_two_sel_o, // Preset speed two chosen
  output logic preset_three_sel_o, // Preset speed three chosen
  output logic mode_switch_req_o, // Control mode switch chosen
  output logic speed_dir_rev_o, // Preset direction reverse
  output logic [`SPD_W-1:0] preset_speed_o, // Chosen preset speed value
  output logic irq_o // Level interrupt
);
  core_s st_reg;
  core_s st_next;
  logic limit_mode;
  logic [`LIM_W-1:0] fwd_lim;
  logic [`LIM_W-1:0] rev_lim;
  logic [`TRQ_W:0] mag;
  logic exceed;

  // R14 motor maximum cap
  function automatic logic [`LIM_W-1:0] eff_limit(input logic [`LIM_W-1:0] lim,
                                                  input logic [`LIM_W-1:0] mmax);
    eff_limit = (lim > mmax) ? mmax : lim;
  endfunction : eff_limit

  // R13 percent range check
  function automatic logic pct_ok(input logic [31:0] d);
    pct_ok = (d[31:`LIM_W] == '0) && (d[`LIM_W-1:0] <= `LIM_PCT_MAX);
  endfunction : pct_ok

  // R6 selector range check
  function automatic logic func_ok(input logic [31:0] d);
    func_ok = (d[31:`FUNC_W] == '0) && (d[`FUNC_W-1:0] <= `FUNC_MAX);
  endfunction : func_ok

  // R10 modes outside internal speed selection
  assign limit_mode = !((st_reg.mode >= `SPEED_MODE_LO) && (st_reg.mode <= `SPEED_MODE_HI));

  // R1 R2 R3 per-direction limit choice from sampled contacts
  assign fwd_lim = eff_limit((limit_mode && st_reg.fwd_on) ? st_reg.fwd_ext : st_reg.fwd_int,
                             st_reg.motor_max);
  assign rev_lim = eff_limit((limit_mode && st_reg.rev_on) ? st_reg.rev_ext : st_reg.rev_int,
                             st_reg.motor_max);

  // R16 magnitude of the signed reference, one bit wider to hold the most negative value
  assign mag = torque_ref_i[`TRQ_W-1] ? ((`TRQ_W+1)'(0) - {torque_ref_i[`TRQ_W-1], torque_ref_i})
                                      : {1'b0, torque_ref_i};
  assign exceed = torque_ref_i[`TRQ_W-1] ? (mag > (`TRQ_W+1)'(rev_lim))
                                         : (mag > (`TRQ_W+1)'(fwd_lim));

  // Next state: bus, sampling, clamping, speed decode, interrupts
  always_comb begin
    st_next = st_reg;
    // R12 R15 contacts sampled active low each cycle
    st_next.fwd_on = !fwd_ext_limit_in_n_i;
    st_next.rev_on = !rev_ext_limit_in_n_i;
    st_next.msw_on = !mode_switch_in_n_i;
    // R16 clamp magnitude, keep sign
    if (!exceed) begin
      st_next.torque_out = torque_ref_i;
    end else if (torque_ref_i[`TRQ_W-1]) begin
      st_next.torque_out = `TRQ_W'(0) - `TRQ_W'(rev_lim);
    end else begin
      st_next.torque_out = `TRQ_W'(fwd_lim);
    end
    // R4 clamp flag
    st_next.clamped = exceed;
    // R11 preset speed decode, only outside limit modes
    if (limit_mode) begin
      st_next.spd_sel = SEL_MODE_SWITCH;
    end else begin
      case ({st_reg.fwd_on, st_reg.rev_on})
        2'b00: st_next.spd_sel = SEL_MODE_SWITCH;
        // Reverse-only picks preset one, forward-only preset three
        2'b01: st_next.spd_sel = SEL_ONE;
        2'b11: st_next.spd_sel = SEL_TWO;
        2'b10: st_next.spd_sel = SEL_THREE;
        default: st_next.spd_sel = SEL_MODE_SWITCH;
      endcase
    end
    st_next.dir_rev = !limit_mode && st_reg.msw_on;
    case (st_next.spd_sel)
      SEL_ONE: st_next.spd_out = st_reg.spd1;
      SEL_TWO: st_next.spd_out = st_reg.spd2;
      SEL_THREE: st_next.spd_out = st_reg.spd3;
      default: st_next.spd_out = `PRESET_RST;
    endcase
    // Register writes; out-of-range values are dropped so the old setting stays
    if (reg_wr_i) begin
      case (reg_addr_i)
        // R13 range-checked limits
        `OFS_FWD_INT_LIMIT: if (pct_ok(reg_wdata_i)) st_next.fwd_int = reg_wdata_i[`LIM_W-1:0];
        `OFS_REV_INT_LIMIT: if (pct_ok(reg_wdata_i)) st_next.rev_int = reg_wdata_i[`LIM_W-1:0];
        `OFS_FWD_EXT_LIMIT: if (pct_ok(reg_wdata_i)) st_next.fwd_ext = reg_wdata_i[`LIM_W-1:0];
        `OFS_REV_EXT_LIMIT: if (pct_ok(reg_wdata_i)) st_next.rev_ext = reg_wdata_i[`LIM_W-1:0];
        `OFS_MOTOR_MAX: if (pct_ok(reg_wdata_i)) st_next.motor_max = reg_wdata_i[`LIM_W-1:0];
        `OFS_CONTROL_MODE: begin
          if (reg_wdata_i <= 32'(`MODE_MAX)) st_next.mode = reg_wdata_i[`MODE_W-1:0];
        end
        // R6 selector range
        `OFS_PAIR_A_FUNC: if (func_ok(reg_wdata_i)) st_next.func_a = reg_wdata_i[`FUNC_W-1:0];
        `OFS_PAIR_B_FUNC: if (func_ok(reg_wdata_i)) st_next.func_b = reg_wdata_i[`FUNC_W-1:0];
        `OFS_PAIR_C_FUNC: if (func_ok(reg_wdata_i)) st_next.func_c = reg_wdata_i[`FUNC_W-1:0];
        `OFS_PRESET_ONE: st_next.spd1 = reg_wdata_i[`SPD_W-1:0];
        `OFS_PRESET_TWO: st_next.spd2 = reg_wdata_i[`SPD_W-1:0];
        `OFS_PRESET_THREE: st_next.spd3 = reg_wdata_i[`SPD_W-1:0];
        `OFS_IRQ_CLEAR: st_next.irq_stat = st_reg.irq_stat & ~reg_wdata_i[`IRQ_W-1:0];
        `OFS_IRQ_ENABLE: st_next.irq_en = reg_wdata_i[`IRQ_W-1:0];
        default: st_next.fwd_int = st_next.fwd_int;
      endcase
    end
    // Events set after the clear so a same-cycle event survives
    if (st_next.clamped && !st_reg.clamped) st_next.irq_stat[`IRQ_CLAMP_ON] = 1'b1;
    if (!st_next.clamped && st_reg.clamped) st_next.irq_stat[`IRQ_CLAMP_OFF] = 1'b1;
    if (st_next.spd_sel != st_reg.spd_sel) st_next.irq_stat[`IRQ_SEL_CHG] = 1'b1;
    // Read data for the cycle after the strobe, zero otherwise and when unmapped
    st_next.rdata = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `OFS_FWD_INT_LIMIT: st_next.rdata = 32'(st_reg.fwd_int);
        `OFS_REV_INT_LIMIT: st_next.rdata = 32'(st_reg.rev_int);
        `OFS_FWD_EXT_LIMIT: st_next.rdata = 32'(st_reg.fwd_ext);
        `OFS_REV_EXT_LIMIT: st_next.rdata = 32'(st_reg.rev_ext);
        `OFS_MOTOR_MAX: st_next.rdata = 32'(st_reg.motor_max);
        `OFS_CONTROL_MODE: st_next.rdata = 32'(st_reg.mode);
        `OFS_PAIR_A_FUNC: st_next.rdata = 32'(st_reg.func_a);
        `OFS_PAIR_B_FUNC: st_next.rdata = 32'(st_reg.func_b);
        `OFS_PAIR_C_FUNC: st_next.rdata = 32'(st_reg.func_c);
        `OFS_PRESET_ONE: st_next.rdata = 32'(st_reg.spd1);
        `OFS_PRESET_TWO: st_next.rdata = 32'(st_reg.spd2);
        `OFS_PRESET_THREE: st_next.rdata = 32'(st_reg.spd3);
        `OFS_STATUS: st_next.rdata = 32'({st_reg.dir_rev, st_reg.spd_sel, st_reg.msw_on,
                                          st_reg.rev_on, st_reg.fwd_on, st_reg.clamped});
        `OFS_IRQ_STATUS: st_next.rdata = 32'(st_reg.irq_stat);
        `OFS_IRQ_ENABLE: st_next.rdata = 32'(st_reg.irq_en);
        default: st_next.rdata = '0;
      endcase
    end
  end

  // State register with documented reset values
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= '0;
      st_reg.fwd_int <= `INT_LIMIT_RST;
      st_reg.rev_int <= `INT_LIMIT_RST;
      // R13 external limits reset to one hundred
      st_reg.fwd_ext <= `EXT_LIMIT_RST;
      st_reg.rev_ext <= `EXT_LIMIT_RST;
      st_reg.motor_max <= `MOTOR_MAX_RST;
      st_reg.mode <= `MODE_RST;
      // R7 selector defaults
      st_reg.func_a <= `PAIR_A_RST;
      st_reg.func_b <= `PAIR_B_RST;
      st_reg.func_c <= `PAIR_C_RST;
      st_reg.spd_sel <= SEL_MODE_SWITCH;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state
  assign reg_rdata_o = st_reg.rdata;
  assign torque_lim_o = st_reg.torque_out;
  assign torque_clamped_out_n_o = !st_reg.clamped;
  assign preset_one_sel_o = st_reg.spd_sel == SEL_ONE;
  assign preset_two_sel_o = st_reg.spd_sel == SEL_TWO;
  assign preset_three_sel_o = st_reg.spd_sel == SEL_THREE;
  assign mode_switch_req_o = !limit_mode && (st_reg.spd_sel == SEL_MODE_SWITCH);
  assign speed_dir_rev_o = st_reg.dir_rev;
  assign preset_speed_o = st_reg.spd_out;
  assign irq_o = |(st_reg.irq_stat & st_reg.irq_en);

  // Three pair routers; each adds one cycle of latency behind the clamp flag
  out_pair_route u_pair_a (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .func_i(st_reg.func_a),
    .position_mode_i(position_mode_i), .position_done_out_n_i(position_done_out_n_i),
    .velocity_match_out_n_i(velocity_match_out_n_i), .rotating_out_n_i(rotating_out_n_i),
    .servo_ready_n_i(servo_ready_n_i), .clamped_n_i(torque_clamped_out_n_o),
    .brake_interlock_out_n_i(brake_interlock_out_n_i), .pair_n_o(pair_a_n_o));
  out_pair_route u_pair_b (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .func_i(st_reg.func_b),
    .position_mode_i(position_mode_i), .position_done_out_n_i(position_done_out_n_i),
    .velocity_match_out_n_i(velocity_match_out_n_i), .rotating_out_n_i(rotating_out_n_i),
    .servo_ready_n_i(servo_ready_n_i), .clamped_n_i(torque_clamped_out_n_o),
    .brake_interlock_out_n_i(brake_interlock_out_n_i), .pair_n_o(pair_b_n_o));
  out_pair_route u_pair_c (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .func_i(st_reg.func_c),
    .position_mode_i(position_mode_i), .position_done_out_n_i(position_done_out_n_i),
    .velocity_match_out_n_i(velocity_match_out_n_i), .rotating_out_n_i(rotating_out_n_i),
    .servo_ready_n_i(servo_ready_n_i), .clamped_n_i(torque_clamped_out_n_o),
    .brake_interlock_out_n_i(brake_interlock_out_n_i), .pair_n_o(pair_c_n_o));

  // Checks on selection and clamping
  a_fwd_ext_pick: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R1
    limit_mode && st_reg.fwd_on |-> fwd_lim == eff_limit(st_reg.fwd_ext, st_reg.motor_max))
    else $error("forward external limit not chosen");
  a_rev_ext_pick: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R2
    limit_mode && st_reg.rev_on |-> rev_lim == eff_limit(st_reg.rev_ext, st_reg.motor_max))
    else $error("reverse external limit not chosen");
  a_int_pick: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R3
    !st_reg.fwd_on |-> fwd_lim == eff_limit(st_reg.fwd_int, st_reg.motor_max))
    else $error("forward internal limit not chosen");
  a_clamp_level: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R4
    !torque_ref_i[`TRQ_W-1] && (mag > (`TRQ_W+1)'(fwd_lim)) |=> !torque_clamped_out_n_o)
    else $error("clamp output not low on excess");
  a_func_range: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R6
    st_reg.func_a <= `FUNC_MAX && st_reg.func_b <= `FUNC_MAX && st_reg.func_c <= `FUNC_MAX)
    else $error("selector out of range");
  a_speed_two: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R11
    !limit_mode && st_reg.fwd_on && st_reg.rev_on ##1 !limit_mode |-> preset_two_sel_o)
    else $error("preset two not selected");
  a_ext_range: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R13
    st_reg.fwd_ext <= `LIM_PCT_MAX && st_reg.rev_ext <= `LIM_PCT_MAX)
    else $error("external limit out of range");
  a_max_cap: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R14
    fwd_lim <= st_reg.motor_max && rev_lim <= st_reg.motor_max)
    else $error("limit above motor maximum");
  a_next_cycle: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R15
    $fell(fwd_ext_limit_in_n_i) |=> st_reg.fwd_on)
    else $error("contact not sampled");
  a_sign_kept: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // R16
    torque_ref_i[`TRQ_W-1] && exceed && rev_lim != '0 |=> torque_lim_o[`TRQ_W-1])
    else $error("negative clamp lost its sign");
  c_fwd_clamp: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    st_reg.fwd_on && limit_mode ##1 !torque_clamped_out_n_o);
  c_rev_clamp: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    torque_ref_i[`TRQ_W-1] && exceed);
  c_preset_three: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    preset_three_sel_o && speed_dir_rev_o);
  c_irq: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) $rose(irq_o));
endmodule : servo_torque_limit_select

//--- testbench.sv
// Self-checking bench for the torque-limit selection block.
// Assumes the package and constants header are compiled first.
`timescale 1ns/100ps
`include "servo_torque_limit_params.svh"
module testbench;
  import servo_torque_limit_pkg::*;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [2:0] close = 3'h0;
  logic fn, rn, mn, clamp_n, pa, pb, pc, s1, s2, s3, msw_req, dir_rev, irq;
  logic [15:0] tref = 16'h0;
  logic [15:0] tlim, pspd;
  logic [4:0] ind_n = 5'h1f; // brake, ready, rotating, match, done
  logic pos_mode = 1'b1;
  int fail_count = 0;
  int num_checks = 0;
  int src[5] = '{0, 2, 3, 0, 4};
  logic [2:0] spd_pin[5] = '{3'h0, 3'h2, 3'h3, 3'h1, 3'h5};
  logic [4:0] spd_exp[5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h03};
  logic [15:0] spd_val[5] = '{16'h0, 16'h0101, 16'h0202, 16'h0303, 16'h0303};
  always #12.5 sys_clk_i = ~sys_clk_i;
  contact_panel u_contact_panel (.sys_clk_i(sys_clk_i), .close_i(close), .fwd_n_o(fn),
    .rev_n_o(rn), .msw_n_o(mn));
  servo_torque_limit_select u_servo_torque_limit_select (.sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .fwd_ext_limit_in_n_i(fn),
    .rev_ext_limit_in_n_i(rn), .mode_switch_in_n_i(mn), .torque_ref_i(tref),
    .torque_lim_o(tlim), .torque_clamped_out_n_o(clamp_n), .position_mode_i(pos_mode),
    .position_done_out_n_i(ind_n[0]), .velocity_match_out_n_i(ind_n[1]),
    .rotating_out_n_i(ind_n[2]), .servo_ready_n_i(ind_n[3]),
    .brake_interlock_out_n_i(ind_n[4]), .pair_a_n_o(pa), .pair_b_n_o(pb), .pair_c_n_o(pc),
    .preset_one_sel_o(s1), .preset_two_sel_o(s2), .preset_three_sel_o(s3),
    .mode_switch_req_o(msw_req), .speed_dir_rev_o(dir_rev), .preset_speed_o(pspd),
    .irq_o(irq));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask : reg_write
  task automatic expect_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1 check(what, rdata, exp);
  endtask : expect_reg
  // Contact and reference change, then wait out sampling plus output register
  task automatic drive(input logic [2:0] c, input logic [15:0] t);
    @(posedge sys_clk_i);
    close <= c;
    tref <= t;
    repeat (5) @(posedge sys_clk_i);
    #1;
  endtask : drive
  // Watchdog so a stuck run still reaches the verdict
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    expect_reg("pair_a_func", `OFS_PAIR_A_FUNC, 32'h0);
    expect_reg("pair_b_func", `OFS_PAIR_B_FUNC, 32'h1);
    expect_reg("pair_c_func", `OFS_PAIR_C_FUNC, 32'h2);
    expect_reg("rev_ext", `OFS_REV_EXT_LIMIT, 32'h64);
    expect_reg("unmapped", 8'hfc, 32'h0);
    reg_write(`OFS_FWD_EXT_LIMIT, 32'h12d);
    expect_reg("fwd_ext", `OFS_FWD_EXT_LIMIT, 32'h64);
    reg_write(`OFS_PAIR_A_FUNC, 32'h5);
    expect_reg("func_a", `OFS_PAIR_A_FUNC, 32'h0);
    $display("test registers done");
    // Limits kept within motor range by the configuring side
    reg_write(`OFS_FWD_EXT_LIMIT, 32'h32);
    reg_write(`OFS_REV_EXT_LIMIT, 32'h50);
    reg_write(`OFS_IRQ_ENABLE, 32'h1);
    drive(3'h0, 16'h0096);
    check("lim_int", tlim, 16'h0096);
    check("clamp_off", clamp_n, 1'b1);
    drive(3'h1, 16'h0032);
    check("clamp_equal", clamp_n, 1'b1);
    drive(3'h1, 16'h0096);
    check("lim_fwd", tlim, 16'h0032);
    check("clamp_on", {clamp_n, irq}, 2'h1);
    reg_write(`OFS_IRQ_CLEAR, 32'h1);
    drive(3'h1, 16'hff6a);
    check("lim_rev_int", {tlim, irq}, 17'h1fed4);
    drive(3'h2, 16'hff6a);
    check("lim_rev", {tlim, irq}, 17'h1ff61);
    expect_reg("irq_stat", `OFS_IRQ_STATUS, 32'h3);
    reg_write(`OFS_FWD_INT_LIMIT, 32'hc8);
    reg_write(`OFS_MOTOR_MAX, 32'h78);
    drive(3'h0, 16'h0096);
    check("lim_motor", tlim, 16'h0078);
    reg_write(`OFS_MOTOR_MAX, 32'h12c);
    $display("test torque done");
    drive(3'h0, 16'h0000);
    for (int c = 0; c < 5; c++) begin
      if (c == 3) begin
        drive(3'h1, 16'h0096);
      end else begin
        @(posedge sys_clk_i);
        ind_n <= ~(5'h01 << src[c]);
      end
      reg_write(`OFS_PAIR_A_FUNC, 32'(c));
      repeat (3) @(posedge sys_clk_i);
      #1 check("pair_a", {pa, pb}, {1'b0, c != 1});
    end
    // Code 0 outside position control follows speed coincidence
    @(posedge sys_clk_i);
    pos_mode <= 1'b0;
    ind_n <= 5'h1d;
    reg_write(`OFS_PAIR_A_FUNC, 32'h0);
    repeat (3) @(posedge sys_clk_i);
    #1 check("pair_a_match", pa, 1'b0);
    $display("test routing done");
    reg_write(`OFS_CONTROL_MODE, 32'h3);
    reg_write(`OFS_PRESET_ONE, 32'h0101);
    reg_write(`OFS_PRESET_TWO, 32'h0202);
    reg_write(`OFS_PRESET_THREE, 32'h0303);
    for (int k = 0; k < 5; k++) begin
      drive(spd_pin[k], 16'h0096);
      check("speed_sel", {msw_req, s1, s2, s3, dir_rev}, spd_exp[k]);
      check("speed_val", {pspd, tlim}, {spd_val[k], 16'h0096});
    end
    reg_write(`OFS_CONTROL_MODE, 32'h8);
    reg_write(`OFS_CONTROL_MODE, 32'he);
    expect_reg("mode", `OFS_CONTROL_MODE, 32'h8);
    drive(3'h1, 16'h0096);
    check("lim_mode8", {tlim, s1, pc}, {16'h0032, 2'h1});
    expect_reg("status", `OFS_STATUS, 32'h3);
    $display("test speed done");
    stop_test();
  end
endmodule : testbench
